// *** pkg/uhc_pkg.sv ***
// constants shared by the hub control core and its port machine
package uhc_pkg;
   localparam int NPORT = 4;
   localparam int CLK_HZ = 10_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
   // times below are in ms, counted by the 1 ms tick
   localparam logic [3:0] OC_DEFAULT_MS = 4'h8;
   localparam logic [3:0] PORT_RESET_MS = 4'ha;
   localparam logic [3:0] CHIRP_MS = 4'h1;
   localparam logic [3:0] HOST_CHIRP_WAIT_MS = 4'h2;
   // serial eeprom fetch
   localparam logic [2:0] SPI_HALF = 3'h4;
   localparam logic [7:0] EE_READ_CMD = 8'h03;
   localparam logic [7:0] EE_START_ADDR = 8'h00;
   localparam logic [6:0] EE_HDR_BITS = 7'h10;
   localparam logic [6:0] EE_LAST_BIT = 7'h4f;
   // configuration byte layout in the fetched image
   localparam int CFG_PORTS_BYTE = 6;
   localparam int CFG_OPT_BYTE = 7;
   localparam int OPT_GANG_BIT = 4;
   localparam int OPT_FS_ONLY_BIT = 5;
   localparam int OPT_SINGLE_TT_BIT = 6;
   // reset values and the multi-TT alternate setting
   localparam logic [6:0] ADDR_RESET = 7'h00;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] ALT_MULTI_TT = 8'h01;
   // hub requests handed over by the serial engine
   localparam logic [3:0] REQ_SET_ADDR = 4'h0;
   localparam logic [3:0] REQ_SET_CONFIG = 4'h1;
   localparam logic [3:0] REQ_SET_IFACE = 4'h2;
   localparam logic [3:0] REQ_SET_PORT_POWER = 4'h3;
   localparam logic [3:0] REQ_CLR_PORT_POWER = 4'h4;
   localparam logic [3:0] REQ_SET_PORT_RESET = 4'h5;
   localparam logic [3:0] REQ_CLR_PORT_ENABLE = 4'h6;
   localparam logic [3:0] REQ_SET_PORT_SUSPEND = 4'h7;
   localparam logic [3:0] REQ_CLR_PORT_SUSPEND = 4'h8;
   localparam logic [3:0] REQ_SET_INDICATOR = 4'h9;
   localparam logic [3:0] REQ_CLR_CHANGE = 4'ha;
   // indicator selectors
   localparam logic [1:0] IND_AUTO = 2'h0;
   localparam logic [1:0] IND_AMBER = 2'h1;
   localparam logic [1:0] IND_GREEN = 2'h2;
endpackage

// *** core/uhc_port.sv ***
// one downstream port: power, reset, enable, suspend, over-current
`timescale 1ns/1ps
module uhc_port
   import uhc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // hub context
   input wire logic tick_ms,
   input wire logic active,
   input wire logic hub_cfg,
   input wire logic hub_susp,
   input wire logic [3:0] oc_limit,
   // host commands, one-cycle pulses
   input wire logic set_power,
   input wire logic clr_power,
   input wire logic set_reset,
   input wire logic clr_enable,
   input wire logic set_susp,
   input wire logic clr_susp,
   input wire logic set_ind,
   input wire logic [1:0] ind_val,
   input wire logic clr_change,
   // line conditions; connect, over-current and resume already synchronised
   input wire logic connect,
   input wire logic oc_act,
   input wire logic resume,
   input wire logic babble,
   // port outputs
   output logic power_n,
   output logic se0,
   output logic enabled,
   output logic suspended,
   output logic led_green,
   output logic led_amber,
   output logic change,
   output logic fwd_resume
);
   typedef enum logic [2:0]
   {
      P_OFF = 3'h0,
      P_DISC = 3'h1,
      P_RESET = 3'h2,
      P_ENA = 3'h3,
      P_SUSP = 3'h4,
      P_DIS = 3'h5
   } uhc_pst_t;

   uhc_pst_t state, next_state;
   logic [3:0] rst_cnt;
   logic [3:0] oc_cnt;
   logic oc_flag;
   logic conn_q;
   logic [1:0] ind_sel;

   // over-current must persist for the configured ms before it counts
   wire powered = (state != P_OFF);
   wire oc_hit = powered && oc_act && (oc_cnt >= oc_limit);
   wire rst_done = tick_ms && (rst_cnt == PORT_RESET_MS - 4'h1);
   wire babble_hit = (state == P_ENA) && babble;
   wire local_res = (state == P_SUSP) && resume && !hub_susp;
   wire conn_evt = powered && (connect != conn_q);
   wire ena_evt = (state == P_RESET) && (next_state == P_ENA);
   wire evt = conn_evt || ena_evt || babble_hit || oc_hit || local_res;
   wire man_green = (ind_sel == IND_GREEN);
   wire man_amber = (ind_sel == IND_AMBER);
   wire next_on = (next_state == P_ENA);

   // port state transitions
   always_comb
   begin
      next_state = state;
      if (!hub_cfg || !active || oc_hit || clr_power)
         next_state = P_OFF;
      else
         unique case (state)
            P_OFF: if (set_power) next_state = P_DISC;
            P_DISC: if (set_reset) next_state = P_RESET;
            P_RESET:
               if (rst_done)
                  next_state = connect ? P_ENA : P_DISC;
            P_ENA:
               if (!connect) next_state = P_DISC;
               else if (babble_hit || clr_enable) next_state = P_DIS;
               else if (set_susp) next_state = P_SUSP;
            P_SUSP:
               if (!connect) next_state = P_DISC;
               else if (clr_enable) next_state = P_DIS;
               else if (clr_susp || local_res) next_state = P_ENA;
            P_DIS:
               if (!connect) next_state = P_DISC;
               else if (set_reset) next_state = P_RESET;
            default: next_state = P_OFF;
         endcase
   end

   // state, timers and sticky flags
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         state <= P_OFF;
         rst_cnt <= 4'h0;
         oc_cnt <= 4'h0;
         oc_flag <= 1'b0;
         conn_q <= 1'b0;
         ind_sel <= IND_AUTO;
         change <= 1'b0;
      end
      else
      begin
         state <= next_state;
         conn_q <= connect;
         if (state != P_RESET)
            rst_cnt <= 4'h0;
         else if (tick_ms)
            rst_cnt <= rst_cnt + 4'h1;
         if (!oc_act || !powered)
            oc_cnt <= 4'h0;
         else if (tick_ms && oc_cnt != 4'hf)
            oc_cnt <= oc_cnt + 4'h1;
         // a fresh over-current beats a power request in the same cycle
         if (oc_hit)
            oc_flag <= 1'b1;
         else if (set_power)
            oc_flag <= 1'b0;
         if (set_ind)
            ind_sel <= ind_val;
         change <= evt || (change && !clr_change);
      end
   end

   // registered pins; manual indicator overrides the automatic green
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         power_n <= 1'b1;
         se0 <= 1'b1;
         enabled <= 1'b0;
         suspended <= 1'b0;
         led_green <= 1'b0;
         led_amber <= 1'b0;
         fwd_resume <= 1'b0;
      end
      else
      begin
         power_n <= (next_state == P_OFF);
         se0 <= !hub_cfg || (next_state == P_RESET);
         enabled <= next_on;
         suspended <= (next_state == P_SUSP);
         led_green <= (ind_sel == IND_AUTO) ? next_on : man_green;
         led_amber <= (ind_sel == IND_AUTO) ? oc_flag : man_amber;
         fwd_resume <= (state == P_SUSP) && resume && hub_susp;
      end
   end
endmodule

// *** core/uhc_hub_ctrl.sv ***
// four-port hub control: eeprom fetch, attach, speed, hub state
`timescale 1ns/1ps
module uhc_hub_ctrl
   import uhc_pkg::*;
#(
   parameter int MS_CYC = MS_CYCLES
)
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // serial eeprom
   output logic ee_sck,
   output logic ee_cs_n,
   output logic ee_mosi,
   input wire logic ee_miso,
   // upstream line, from transceiver logic on this clock
   input wire logic upstream_supply_sense,
   input wire logic up_bus_reset,
   input wire logic up_host_chirp,
   input wire logic up_suspend,
   output logic up_pullup_en,
   output logic up_chirp_k,
   output logic up_resume,
   // decoded hub requests from the serial_interface_engine
   input wire logic req_valid,
   input wire logic [3:0] req_code,
   input wire logic [1:0] req_port,
   input wire logic [7:0] req_value,
   // hub state
   output logic cfg_loaded,
   output logic hs_mode,
   output logic multi_tt,
   output logic hub_configured,
   output logic [6:0] dev_addr,
   output logic [15:0] vendor_id,
   output logic [15:0] product_id,
   output logic [15:0] device_id,
   output logic status_change,
   // downstream ports
   input wire logic [NPORT-1:0] port_connect,
   input wire logic [NPORT-1:0] port_overcurrent_input_n,
   input wire logic [NPORT-1:0] port_resume,
   input wire logic [NPORT-1:0] port_babble,
   input wire logic [NPORT-1:0] port_hs_device,
   output logic [NPORT-1:0] port_power_enable_n,
   output logic [NPORT-1:0] port_se0,
   output logic [NPORT-1:0] port_enabled,
   output logic [NPORT-1:0] port_suspended,
   output logic [NPORT-1:0] port_led_green,
   output logic [NPORT-1:0] port_led_amber,
   output logic [NPORT-1:0] port_change,
   output logic [NPORT-1:0] port_removable,
   output logic [NPORT-1:0] port_route_tt,
   output logic tt_broadcast,
   output logic force_legacy
);
   typedef enum logic [2:0]
   {
      U_LOAD = 3'h0,
      U_DETACH = 3'h1,
      U_ATTACH = 3'h2,
      U_CHIRP = 3'h3,
      U_WAIT = 3'h4,
      U_FS = 3'h5,
      U_HS = 3'h6
   } uhc_ust_t;

   // pin synchronisers
   logic [1:0] sense_sy;
   logic [1:0] miso_sy;
   logic [NPORT-1:0] conn_m, conn_s;
   logic [NPORT-1:0] oc_m, oc_s;
   logic [NPORT-1:0] res_m, res_s;

   // eeprom engine
   logic [2:0] div_cnt;
   logic [6:0] bit_cnt;
   logic [15:0] cmd_sh;
   logic [63:0] ee_sh;
   logic loading;

   // upstream and hub state
   uhc_ust_t ustate, next_ustate;
   logic [15:0] tick_cnt;
   logic tick_ms;
   logic [3:0] ms_cnt;
   logic bus_reset_q;
   logic [7:0] config_val;
   logic [7:0] alt_setting;
   logic hub_susp;

   // per-port wires from the port machines
   logic [NPORT-1:0] p_port_power_enable, p_se0, p_ena, p_susp;
   logic [NPORT-1:0] p_green, p_amber, p_chg, p_fwd;

   // image bytes, first byte fetched sits at the top of the shifter
   wire [7:0] ports_byte = ee_sh[63 - 8*CFG_PORTS_BYTE -: 8];
   wire [7:0] opt_byte = ee_sh[63 - 8*CFG_OPT_BYTE -: 8];
   wire [NPORT-1:0] active_mask = ports_byte[NPORT-1:0];
   wire [NPORT-1:0] remov_mask = ports_byte[7 -: NPORT];
   wire [3:0] oc_cfg = opt_byte[3:0];
   wire gang = opt_byte[OPT_GANG_BIT];
   wire fs_only = opt_byte[OPT_FS_ONLY_BIT];
   wire single_only = opt_byte[OPT_SINGLE_TT_BIT];
   // a blank image gives zero ms, so fall back on the default timer
   wire [3:0] oc_limit = (oc_cfg == 4'h0) ? OC_DEFAULT_MS : oc_cfg;

   // spi timing: a half period ends each SPI_HALF cycles
   wire half_end = (div_cnt == SPI_HALF - 3'h1);
   wire sample = loading && half_end && ee_sck;
   wire load_done = sample && (bit_cnt == EE_LAST_BIT);

   // upstream events
   wire sense = sense_sy[1];
   wire bus_reset_evt = up_bus_reset && !bus_reset_q;
   wire running = (ustate == U_FS) || (ustate == U_HS);
   wire ms_end_chirp = tick_ms && (ms_cnt == CHIRP_MS - 4'h1);
   wire ms_end_wait = tick_ms && (ms_cnt == HOST_CHIRP_WAIT_MS - 4'h1);

   // request decode; the engine delivers only checked, addressed requests
   wire req_ok = req_valid && running;
   wire do_addr = req_ok && (req_code == REQ_SET_ADDR);
   wire do_cfg = req_ok && (req_code == REQ_SET_CONFIG);
   wire do_alt = req_ok && (req_code == REQ_SET_IFACE) && hub_configured;
   wire [NPORT-1:0] sel_one = NPORT'(1) << req_port;
   // ganged switching applies power requests to every port
   wire [NPORT-1:0] sel_pwr = gang ? {NPORT{1'b1}} : sel_one;
   wire [NPORT-1:0] c_spwr = (req_ok && req_code == REQ_SET_PORT_POWER)
                             ? sel_pwr : '0;
   wire [NPORT-1:0] c_cpwr = (req_ok && req_code == REQ_CLR_PORT_POWER)
                             ? sel_pwr : '0;
   wire [NPORT-1:0] c_rst = (req_ok && req_code == REQ_SET_PORT_RESET)
                            ? sel_one : '0;
   wire [NPORT-1:0] c_cena = (req_ok && req_code == REQ_CLR_PORT_ENABLE)
                             ? sel_one : '0;
   wire [NPORT-1:0] c_ssus = (req_ok && req_code == REQ_SET_PORT_SUSPEND)
                             ? sel_one : '0;
   wire [NPORT-1:0] c_csus = (req_ok && req_code == REQ_CLR_PORT_SUSPEND)
                             ? sel_one : '0;
   wire [NPORT-1:0] c_ind = (req_ok && req_code == REQ_SET_INDICATOR)
                            ? sel_one : '0;
   wire [NPORT-1:0] c_cchg = (req_ok && req_code == REQ_CLR_CHANGE)
                             ? sel_one : '0;

   // speed and routing decisions
   wire next_multi = hs_mode && hub_configured && !single_only
                     && (alt_setting == ALT_MULTI_TT);
   wire [NPORT-1:0] next_route = hs_mode ? (p_ena & ~port_hs_device)
                                         : '0;

   // two flops on the sense, miso, connect, over-current and resume pins before any use
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         sense_sy <= 2'h0;
         miso_sy <= 2'h0;
         conn_m <= '0;
         conn_s <= '0;
         oc_m <= '0;
         oc_s <= '0;
         res_m <= '0;
         res_s <= '0;
      end
      else
      begin
         sense_sy <= {sense_sy[0], upstream_supply_sense};
         miso_sy <= {miso_sy[0], ee_miso};
         conn_m <= port_connect;
         conn_s <= conn_m;
         oc_m <= ~port_overcurrent_input_n;
         oc_s <= oc_m;
         res_m <= port_resume;
         res_s <= res_m;
      end
   end

   // spi clock divider; slow enough that the synced miso is settled
   always_ff @(posedge clock)
   begin
      if (!resetn || !loading || half_end)
         div_cnt <= 3'h0;
      else
         div_cnt <= div_cnt + 3'h1;
   end

   // eeprom read: command and address out, then eight bytes in
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         loading <= 1'b1;
         ee_cs_n <= 1'b1;
         ee_sck <= 1'b0;
         ee_mosi <= 1'b0;
         bit_cnt <= 7'h00;
         cmd_sh <= {EE_READ_CMD, EE_START_ADDR};
         ee_sh <= '0;
      end
      else if (loading)
      begin
         ee_cs_n <= 1'b0;
         // settles well before the next rising sck
         ee_mosi <= cmd_sh[15];
         if (half_end && !ee_cs_n)
         begin
            ee_sck <= !ee_sck;
            if (ee_sck)
            begin
               bit_cnt <= bit_cnt + 7'h01;
               cmd_sh <= {cmd_sh[14:0], 1'b0};
               if (bit_cnt >= EE_HDR_BITS)
                  ee_sh <= {ee_sh[62:0], miso_sy[1]};
            end
         end
         if (load_done)
         begin
            loading <= 1'b0;
            ee_cs_n <= 1'b1;
            ee_sck <= 1'b0;
         end
      end
   end

   // 1 ms tick drives all port and chirp timing
   always_ff @(posedge clock)
   begin
      if (!resetn || tick_ms)
         tick_cnt <= 16'h0000;
      else
         tick_cnt <= tick_cnt + 16'h0001;
      if (!resetn)
         tick_ms <= 1'b0;
      else
         tick_ms <= (tick_cnt == 16'(MS_CYC - 2));
   end

   // upstream attach and speed negotiation
   always_comb
   begin
      next_ustate = ustate;
      if (ustate == U_LOAD)
      begin
         if (load_done) next_ustate = U_DETACH;
      end
      else if (!sense)
         next_ustate = U_DETACH;
      else
         unique case (ustate)
            U_DETACH: next_ustate = U_ATTACH;
            U_ATTACH: if (bus_reset_evt) next_ustate = U_CHIRP;
            U_CHIRP:
               if (fs_only) next_ustate = U_FS;
               else if (ms_end_chirp) next_ustate = U_WAIT;
            U_WAIT:
               if (up_host_chirp) next_ustate = U_HS;
               else if (ms_end_wait) next_ustate = U_FS;
            U_FS: if (bus_reset_evt) next_ustate = U_CHIRP;
            U_HS: if (bus_reset_evt) next_ustate = U_CHIRP;
            default: next_ustate = U_DETACH;
         endcase
   end

   // upstream state, chirp timer and line controls
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         ustate <= U_LOAD;
         ms_cnt <= 4'h0;
         bus_reset_q <= 1'b0;
         up_pullup_en <= 1'b0;
         up_chirp_k <= 1'b0;
         hs_mode <= 1'b0;
      end
      else
      begin
         ustate <= next_ustate;
         bus_reset_q <= up_bus_reset;
         if (next_ustate != ustate)
            ms_cnt <= 4'h0;
         else if (tick_ms)
            ms_cnt <= ms_cnt + 4'h1;
         // pull-up stays on through full speed, off at high speed
         up_pullup_en <= (next_ustate == U_ATTACH)
                         || (next_ustate == U_CHIRP)
                         || (next_ustate == U_WAIT)
                         || (next_ustate == U_FS);
         up_chirp_k <= (next_ustate == U_CHIRP) && !fs_only;
         hs_mode <= (next_ustate == U_HS);
      end
   end

   // address, configuration and alternate setting
   always_ff @(posedge clock)
   begin
      if (!resetn || bus_reset_evt || !running)
      begin
         dev_addr <= ADDR_RESET;
         config_val <= CONFIG_RESET;
         alt_setting <= CONFIG_RESET;
      end
      else if (do_addr)
      begin
         dev_addr <= req_value[6:0];
         config_val <= CONFIG_RESET;
         alt_setting <= CONFIG_RESET;
      end
      else if (do_cfg)
      begin
         config_val <= req_value;
         alt_setting <= CONFIG_RESET;
      end
      else if (do_alt)
         alt_setting <= req_value;
   end

   // hub-level registered outputs
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         hub_configured <= 1'b0;
         hub_susp <= 1'b0;
         multi_tt <= 1'b0;
         tt_broadcast <= 1'b0;
         force_legacy <= 1'b1;
         port_route_tt <= '0;
         up_resume <= 1'b0;
         status_change <= 1'b0;
         cfg_loaded <= 1'b0;
      end
      else
      begin
         hub_configured <= (config_val != CONFIG_RESET);
         hub_susp <= running && up_suspend;
         multi_tt <= next_multi;
         tt_broadcast <= hs_mode && !next_multi;
         force_legacy <= !hs_mode;
         port_route_tt <= next_route;
         up_resume <= |p_fwd;
         status_change <= |p_chg;
         cfg_loaded <= cfg_loaded || load_done;
      end
   end

   // identity and port attributes are held from the fetched image
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         vendor_id <= 16'h0000;
         product_id <= 16'h0000;
         device_id <= 16'h0000;
         port_removable <= '0;
      end
      else if (cfg_loaded)
      begin
         vendor_id <= {ee_sh[55:48], ee_sh[63:56]};
         product_id <= {ee_sh[39:32], ee_sh[47:40]};
         device_id <= {ee_sh[23:16], ee_sh[31:24]};
         port_removable <= remov_mask & active_mask;
      end
   end

   // one port machine per downstream port
   generate
      for (genvar i = 0; i < NPORT; i++)
      begin : g_port
         uhc_port u_port
         (
            .clock(clock),
            .resetn(resetn),
            .tick_ms(tick_ms),
            .active(active_mask[i] && cfg_loaded),
            .hub_cfg(hub_configured),
            .hub_susp(hub_susp),
            .oc_limit(oc_limit),
            .set_power(c_spwr[i]),
            .clr_power(c_cpwr[i]),
            .set_reset(c_rst[i]),
            .clr_enable(c_cena[i]),
            .set_susp(c_ssus[i]),
            .clr_susp(c_csus[i]),
            .set_ind(c_ind[i]),
            .ind_val(req_value[1:0]),
            .clr_change(c_cchg[i]),
            .connect(conn_s[i]),
            .oc_act(oc_s[i]),
            .resume(res_s[i]),
            .babble(port_babble[i]),
            .power_n(p_port_power_enable[i]),
            .se0(p_se0[i]),
            .enabled(p_ena[i]),
            .suspended(p_susp[i]),
            .led_green(p_green[i]),
            .led_amber(p_amber[i]),
            .change(p_chg[i]),
            .fwd_resume(p_fwd[i])
         );
      end
   endgenerate

   // port pins come straight from the port machine flops
   assign port_power_enable_n = p_port_power_enable;
   assign port_se0 = p_se0;
   assign port_enabled = p_ena;
   assign port_suspended = p_susp;
   assign port_led_green = p_green;
   assign port_led_amber = p_amber;
   assign port_change = p_chg;
endmodule

// *** tb/uhc_ee_model.sv ***
// serial eeprom model serving one configuration image
`timescale 1ns/1ps
module uhc_ee_model
#(
   parameter logic [63:0] IMG = 64'h0
)
(
   // spi pins
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso
);
   int n = 0;
   initial miso = 1'b0;
   // bit count, taken on rising sck, cleared by deselect
   always @(posedge sck or posedge cs_n)
      n <= cs_n ? 0 : n + 1;
   // idle line toggles so a stale bit never passes for data
   always @(negedge sck or posedge cs_n)
      miso <= (cs_n || n < 16 || n > 79) ? ~miso : IMG[79 - n];
endmodule

// *** tb/uhc_hub_chk.sv ***
// hub control port assertions
`timescale 1ns/1ps
module uhc_hub_chk
   import uhc_pkg::*;
(
   // clock, reset and upstream
   input wire logic clock,
   input wire logic resetn,
   input wire logic upstream_supply_sense,
   input wire logic up_bus_reset,
   input wire logic up_pullup_en,
   input wire logic up_chirp_k,
   // requests, hub state, ports
   input wire logic req_valid,
   input wire logic [3:0] req_code,
   input wire logic cfg_loaded,
   input wire logic hs_mode,
   input wire logic hub_configured,
   input wire logic [6:0] dev_addr,
   input wire logic force_legacy,
   input wire logic [NPORT-1:0] port_babble,
   input wire logic [NPORT-1:0] port_power_enable_n,
   input wire logic [NPORT-1:0] port_se0,
   input wire logic [NPORT-1:0] port_enabled
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // port outputs lag the hub state by up to two edges
   sequence s_new_addr;
      req_valid && req_code == REQ_SET_ADDR && hub_configured;
   endsequence
   sequence s_unconf;
      !hub_configured [*3];
   endsequence
   a_no_early: assert property (!cfg_loaded |-> !up_pullup_en)
      else $error("pull-up before fetch");
   a_no_sense: assert property (
      !upstream_supply_sense [*6] |-> !up_pullup_en)
      else $error("pull-up without supply");
   a_chirp_go: assert property (
      $rose(up_bus_reset) && up_pullup_en |-> ##[1:2] up_chirp_k)
      else $error("no chirp on bus reset");
   a_hs_pullup: assert property ($rose(hs_mode) |-> !up_pullup_en)
      else $error("pull-up left on at high speed");
   a_hs_legacy: assert property (
      $rose(hs_mode) |-> ##[0:1] !force_legacy)
      else $error("legacy kept at high speed");
   a_bus_clear: assert property (
      $rose(up_bus_reset) |-> ##[1:3] dev_addr == ADDR_RESET && !hub_configured)
      else $error("bus reset left state");
   a_addr_unconf: assert property (s_new_addr |-> ##[1:3] !hub_configured)
      else $error("still configured after address");
   a_unconf_ports: assert property (
      s_unconf |-> &port_se0 && &port_power_enable_n)
      else $error("port live while unconfigured");
   a_babble_off: assert property (
      (port_enabled & port_babble) != 4'h0 |-> ##[1:3]
      (port_enabled & port_babble) == 4'h0)
      else $error("port kept after babble");
endmodule

// *** tb/tb_top.sv ***
// hub control bench with eeprom model
`timescale 1ns/1ps
module tb_top;
   import uhc_pkg::*;
   localparam int MSC = 20;
   localparam logic [63:0] IMG = 64'h3412_7856_bc9a_5f02;
   logic clock = 1'b0, resetn = 1'b0, up_suspend = 1'b0, req_valid = 1'b0;
   logic upstream_supply_sense = 1'b0, up_bus_reset = 1'b0;
   logic up_host_chirp = 1'b0, ee_miso, ee_sck, ee_cs_n, ee_mosi;
   logic up_pullup_en, up_chirp_k, cfg_loaded, hs_mode, multi_tt;
   logic hub_configured, status_change, force_legacy;
   logic [1:0] req_port = 2'h0, p;
   logic [3:0] req_code = 4'h0, port_connect = 4'h0, port_babble = 4'h0;
   logic [3:0] port_overcurrent_input_n = 4'hf, port_resume = 4'h0;
   logic [3:0] port_hs_device = 4'h0, port_power_enable_n, port_se0;
   logic [3:0] port_enabled, port_led_green, port_led_amber;
   logic [3:0] port_change, port_removable;
   logic [6:0] dev_addr, addr;
   logic [7:0] req_value = 8'h00;
   logic [15:0] vendor_id, product_id, device_id;
   int n_errors = 0, checks_done = 0, seed = 74914, i;
   uhc_hub_ctrl #(.MS_CYC(MSC)) i_uhc_hub_ctrl (.*, .up_resume(),
      .port_suspended(), .port_route_tt(), .tt_broadcast());
   uhc_ee_model #(.IMG(IMG)) i_uhc_ee_model (.sck(ee_sck), .cs_n(ee_cs_n),
      .mosi(ee_mosi), .miso(ee_miso));
   // little-endian id from image byte pair k
   function automatic logic [15:0] le16(input int k);
      return {IMG[55-16*k -: 8], IMG[63-16*k -: 8]};
   endfunction
   task chk(input logic [47:0] v, input logic [47:0] e);
      checks_done++;
      if (v !== e)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, v, e);
      end
   endtask
   task end_sim();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // a missed handshake ends the run at once
   task need(input logic ok);
      chk(ok, 1'b1);
      if (ok !== 1'b1)
         end_sim();
   endtask
   // one-cycle strobe, then room for the two-edge answer
   task req(input logic [3:0] c, input logic [1:0] pp, input logic [7:0] v);
      req_code = c;
      req_port = pp;
      req_value = v;
      req_valid = 1'b1;
      @(negedge clock);
      req_valid = 1'b0;
      repeat (4) @(negedge clock);
   endtask
   task prst();
      req(REQ_SET_PORT_RESET, p, 8'h00);
      chk(port_se0[p], 1'b1);
      for (i = 0; i < 400 && port_enabled[p] !== 1'b1; i++)
         @(negedge clock);
      need(port_enabled[p]);
   endtask
   initial
   begin
      forever #50 clock = ~clock;
   end
   // main sequence, inputs change on the falling edge
   initial
   begin
      repeat (3) @(negedge clock);
      resetn = 1'b1;
      for (i = 0; i < 2000 && cfg_loaded !== 1'b1; i++)
         @(negedge clock);
      need(cfg_loaded);
      @(negedge clock);
      chk(up_pullup_en, 1'b0);
      chk({vendor_id, product_id, device_id}, {le16(0), le16(1), le16(2)});
      chk(port_removable, IMG[11:8] & IMG[15:12]);
      upstream_supply_sense = 1'b1;
      repeat (6) @(negedge clock);
      chk(up_pullup_en, 1'b1);
      up_bus_reset = 1'b1;
      repeat (3) @(negedge clock);
      chk(up_chirp_k, 1'b1);
      for (i = 0; i < 200 && up_chirp_k !== 1'b0; i++)
         @(negedge clock);
      need(~up_chirp_k);
      up_host_chirp = 1'b1;
      repeat (3) @(negedge clock);
      chk({hs_mode, up_pullup_en, force_legacy}, 3'h4);
      up_host_chirp = 1'b0;
      up_bus_reset = 1'b0;
      addr = $random(seed);
      req(REQ_SET_ADDR, 2'h0, {1'b0, addr});
      chk(dev_addr, addr);
      req(REQ_SET_CONFIG, 2'h0, 8'h01);
      chk({hub_configured, multi_tt, port_se0}, 6'h20);
      req(REQ_SET_IFACE, 2'h0, ALT_MULTI_TT);
      chk(multi_tt, 1'b1);
      for (i = 0; i < 4; i++)
      begin
         req(REQ_SET_PORT_POWER, i[1:0], 8'h00);
         chk(port_power_enable_n, 4'(4'hf << (i + 1)));
      end
      port_connect = 4'hf;
      p = $random(seed);
      prst();
      chk({port_led_green[p], port_change[p], status_change}, 3'h7);
      req(REQ_CLR_PORT_ENABLE, p, 8'h00);
      chk(port_enabled[p], 1'b0);
      prst();
      port_babble[p] = 1'b1;
      repeat (4) @(negedge clock);
      chk(port_enabled[p], 1'b0);
      port_babble[p] = 1'b0;
      port_overcurrent_input_n[p] = 1'b0;
      for (i = 0; i < 200 && port_power_enable_n[p] !== 1'b1; i++)
         @(negedge clock);
      @(negedge clock);
      need(port_power_enable_n[p] & port_led_amber[p]);
      chk(i >= (IMG[3:0] - 1) * MSC, 1'b1);
      req(REQ_SET_ADDR, 2'h0, 8'h11);
      chk({hub_configured, port_se0, port_power_enable_n}, 9'h0ff);
      up_bus_reset = 1'b1;
      repeat (3) @(negedge clock);
      chk(dev_addr, ADDR_RESET);
      end_sim();
   end
endmodule
bind uhc_hub_ctrl uhc_hub_chk i_uhc_hub_chk (.*);
